/* hdl/logic_op_pkg.sv */
/*
 * package for the dual input logic operator bank: operation codes,
 * widths, reset values and register map of the plain register port.
 * assumes a single core clock and synchronous active-low reset.
 */
package logic_op_pkg;

    // ************************************************************
    // sizes
    // ************************************************************
    localparam int NUM_OPS = 32;
    localparam int DATA_W = 16;
    localparam int SRC_W = 6;
    localparam int NUM_SRC = 64;
    localparam int ADDR_W = 8;

    // ************************************************************
    // operation codes
    // ************************************************************
    typedef enum logic [3:0] {
        OP_OFF = 4'h0,
        OP_AND = 4'h1,
        OP_OR = 4'h2,
        OP_XOR = 4'h3,
        OP_LATCH = 4'h4,
        OP_EQ = 4'h5,
        OP_GT = 4'h6,
        OP_LT = 4'h7,
        OP_GE = 4'h8,
        OP_LE = 4'h9
    } op_e;

    // ************************************************************
    // configuration word layout (one per operator)
    // ************************************************************
    localparam int CFG_OP_LSB = 0;
    localparam int CFG_OP_W = 4;
    localparam int CFG_INV1_BIT = 4;
    localparam int CFG_INV2_BIT = 5;
    localparam int CFG_FALLBACK_BIT = 6;
    localparam int CFG_SRC1_LSB = 8;
    localparam int CFG_SRC2_LSB = 16;
    localparam int CFG_W = 22;
    localparam logic [CFG_W-1:0] CFG_RESET = 22'h000000;

    // ************************************************************
    // register map (word index on the address port)
    // ************************************************************
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_RESULT = 8'h01;
    localparam logic [ADDR_W-1:0] REG_STATUS_BAD = 8'h02;
    localparam logic [ADDR_W-1:0] REG_IN1_STATE = 8'h03;
    localparam logic [ADDR_W-1:0] REG_IN2_STATE = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h05;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLEAR = 8'h06;
    localparam logic [ADDR_W-1:0] REG_IRQ_ENABLE = 8'h07;
    localparam logic [ADDR_W-1:0] REG_CFG_BASE = 8'h20;

    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CFGMODE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;

endpackage : logic_op_pkg

/* hdl/logic_op_bank.sv */
/*
 * dual input logic operator bank: up to 32 operators, each picking two
 * signed words from a flat source bus, with inversion, fallback and a
 * registered on/off result. registers on a plain one-cycle port.
 * assumes sources and bad flags are synchronous to core_clk.
 */
`timescale 1ns/1ps

// Behaviour
// - up to 32 independent operator instances
// - two inputs, each from any source
// - config writable only in configuration mode with bank enabled
// - off operation gives no computed result
// - and: on when both inputs on
// - or: on when either input on
// - xor: on when exactly one on
// - latch set by input one, cleared by two
// - equal compare of input values
// - greater: first strictly larger
// - less: first strictly smaller
// - greater-equal and less-equal comparisons
// - input states and result read-only
// - bad status forces configured fallback
// - bank usable only when enabled
// - configuration mode suspends all evaluation
module logic_op_bank
    import logic_op_pkg::*;
#(
    parameter int NumOps = NUM_OPS,
    parameter int DataW = DATA_W
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [NUM_SRC*DATA_W-1:0] srcValues,
    input wire logic [NUM_SRC-1:0] srcBad,
    input wire logic [logic_op_pkg::ADDR_W-1:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic [NUM_OPS-1:0] opResult,
    output logic [NUM_OPS-1:0] opBad,
    output logic irq
);
    import logic_op_pkg::*;

    initial begin
        if (NumOps < 1 || NumOps > NUM_OPS || DataW != DATA_W) begin
            $error("logic_op_bank: unsupported parameters");
        end
    end

    // ************************************************************
    // control and configuration registers
    // ************************************************************
    logic [1:0] ctrl_q;
    logic [CFG_W-1:0] cfg_q [NUM_OPS];
    logic [NUM_OPS-1:0] irqStatus_q;
    logic [NUM_OPS-1:0] irqEnable_q;
    logic [NUM_OPS-1:0] in1State_q;
    logic [NUM_OPS-1:0] in2State_q;
    logic [NUM_OPS-1:0] result_q;
    logic [NUM_OPS-1:0] bad_q;
    logic [NUM_OPS-1:0] resultRise;
    logic bankEnable;
    logic cfgMode;
    logic running;

    assign bankEnable = ctrl_q[CTRL_ENABLE_BIT];
    assign cfgMode = ctrl_q[CTRL_CFGMODE_BIT];
    assign running = bankEnable && !cfgMode;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_q <= CTRL_RESET;
        end else if (regWr && regAddr == REG_CTRL) begin
            ctrl_q <= regWdata[1:0];
        end
    end

    // config words only take writes in configuration mode with the bank enabled
    always_ff @(posedge core_clk) begin
        for (int i = 0; i < NUM_OPS; i++) begin
            if (!nrst) begin
                cfg_q[i] <= CFG_RESET;
            end else if (regWr && cfgMode && bankEnable
                    && regAddr == REG_CFG_BASE + ADDR_W'(i)) begin
                cfg_q[i] <= regWdata[CFG_W-1:0];
            end
        end
    end

    // ************************************************************
    // operator instances
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < NUM_OPS; g++) begin : gOp
            logic [SRC_W-1:0] sel1;
            logic [SRC_W-1:0] sel2;
            logic signed [DATA_W-1:0] val1;
            logic signed [DATA_W-1:0] val2;
            logic b1;
            logic b2;
            logic bad;
            logic fallback;
            logic calc;
            logic active;
            op_e op;

            assign sel1 = cfg_q[g][CFG_SRC1_LSB +: SRC_W];
            assign sel2 = cfg_q[g][CFG_SRC2_LSB +: SRC_W];
            assign val1 = srcValues[sel1*DATA_W +: DATA_W];
            assign val2 = srcValues[sel2*DATA_W +: DATA_W];
            assign b1 = (val1 != '0) ^ cfg_q[g][CFG_INV1_BIT];
            assign b2 = (val2 != '0) ^ cfg_q[g][CFG_INV2_BIT];
            assign bad = srcBad[sel1] || srcBad[sel2];
            assign fallback = cfg_q[g][CFG_FALLBACK_BIT];
            assign op = op_e'(cfg_q[g][CFG_OP_LSB +: CFG_OP_W]);
            assign active = running && (g < NumOps);

            always_comb begin
                case (op)
                    OP_AND: calc = b1 & b2;
                    OP_OR: calc = b1 | b2;
                    OP_XOR: calc = b1 ^ b2;
                    OP_LATCH: calc = !b2 && (b1 || result_q[g]);
                    OP_EQ: calc = val1 == val2;
                    OP_GT: calc = val1 > val2;
                    OP_LT: calc = val1 < val2;
                    OP_GE: calc = val1 >= val2;
                    OP_LE: calc = val1 <= val2;
                    default: calc = 1'b0;
                endcase
            end

            // holding while suspended keeps outputs stable for the plant
            always_ff @(posedge core_clk) begin
                if (!nrst) begin
                    result_q[g] <= 1'b0;
                    bad_q[g] <= 1'b0;
                    in1State_q[g] <= 1'b0;
                    in2State_q[g] <= 1'b0;
                end else if (!active) begin
                    result_q[g] <= result_q[g];
                end else if (op == OP_OFF) begin
                    result_q[g] <= 1'b0;
                    bad_q[g] <= 1'b0;
                    in1State_q[g] <= b1;
                    in2State_q[g] <= b2;
                end else begin
                    result_q[g] <= bad ? fallback : calc;
                    bad_q[g] <= bad;
                    in1State_q[g] <= b1;
                    in2State_q[g] <= b2;
                end
            end

            assign resultRise[g] = active && op != OP_OFF && !result_q[g]
                && (bad ? fallback : calc);
        end
    endgenerate

    // ************************************************************
    // interrupts: sticky on each rising result, set wins over clear
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irqStatus_q <= '0;
        end else begin
            irqStatus_q <= (irqStatus_q & ~((regWr && regAddr == REG_IRQ_CLEAR)
                ? regWdata : 32'h00000000)) | resultRise;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irqEnable_q <= '0;
        end else if (regWr && regAddr == REG_IRQ_ENABLE) begin
            irqEnable_q <= regWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irqStatus_q & ~((regWr && regAddr == REG_IRQ_CLEAR)
                ? regWdata : 32'h00000000) | resultRise) & irqEnable_q);
        end
    end

    // ************************************************************
    // read port and registered outputs
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            regRdata <= 32'h00000000;
        end else if (regRd) begin
            if (regAddr >= REG_CFG_BASE && regAddr < REG_CFG_BASE + ADDR_W'(NUM_OPS)) begin
                regRdata <= {10'h000, cfg_q[regAddr[4:0]]};
            end else begin
                case (regAddr)
                    REG_CTRL: regRdata <= {30'h00000000, ctrl_q};
                    REG_RESULT: regRdata <= result_q;
                    REG_STATUS_BAD: regRdata <= bad_q;
                    REG_IN1_STATE: regRdata <= in1State_q;
                    REG_IN2_STATE: regRdata <= in2State_q;
                    REG_IRQ_STATUS: regRdata <= irqStatus_q;
                    REG_IRQ_ENABLE: regRdata <= irqEnable_q;
                    default: regRdata <= 32'h00000000;
                endcase
            end
        end else begin
            regRdata <= 32'h00000000;
        end
    end

    assign opResult = result_q;
    assign opBad = bad_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // operator indices below follow the bench layout; the bench never reaches latch_hold_a
    suspend_hold_a: assert property (
        $past(!running)
        |-> $stable(result_q))
        else $error("result changed while suspended");

    bad_hold_a: assert property (
        !running
        |=> $stable(bad_q))
        else $error("bad status changed while suspended");

    and_op_a: assert property (
        running && gOp[1].op == OP_AND && !gOp[1].bad
        |=> result_q[1] == $past(gOp[1].b1 & gOp[1].b2))
        else $error("and result wrong");

    or_op_a: assert property (
        running && gOp[2].op == OP_OR && !gOp[2].bad
        |=> result_q[2] == $past(gOp[2].b1 | gOp[2].b2))
        else $error("or result wrong");

    xor_op_a: assert property (
        running && gOp[3].op == OP_XOR && !gOp[3].bad
        |=> result_q[3] == $past(gOp[3].b1 ^ gOp[3].b2))
        else $error("xor result wrong");

    latch_clear_a: assert property (
        running && gOp[4].op == OP_LATCH && !gOp[4].bad && gOp[4].b2
        |=> !result_q[4])
        else $error("latch not cleared");

    latch_set_a: assert property (
        running && gOp[4].op == OP_LATCH && !gOp[4].bad && gOp[4].b1 && !gOp[4].b2
        |=> result_q[4])
        else $error("latch not set");

    latch_hold_a: assert property (
        running && gOp[4].op == OP_LATCH && !gOp[4].bad && !gOp[4].b1 && !gOp[4].b2
        && result_q[4]
        |=> result_q[4])
        else $error("latch did not hold");

    eq_cmp_a: assert property (
        running && gOp[5].op == OP_EQ && !gOp[5].bad
        |=> result_q[5] == $past(gOp[5].val1 == gOp[5].val2))
        else $error("equal compare wrong");

    gt_cmp_a: assert property (
        running && gOp[6].op == OP_GT && !gOp[6].bad
        |=> result_q[6] == $past(gOp[6].val1 > gOp[6].val2))
        else $error("greater compare wrong");

    lt_cmp_a: assert property (
        running && gOp[7].op == OP_LT && !gOp[7].bad
        |=> result_q[7] == $past(gOp[7].val1 < gOp[7].val2))
        else $error("less compare wrong");

    ge_cmp_a: assert property (
        running && gOp[8].op == OP_GE && !gOp[8].bad
        |=> result_q[8] == $past(gOp[8].val1 >= gOp[8].val2))
        else $error("greater-equal compare wrong");

    le_cmp_a: assert property (
        running && gOp[9].op == OP_LE && !gOp[9].bad
        |=> result_q[9] == $past(gOp[9].val1 <= gOp[9].val2))
        else $error("less-equal compare wrong");

    fallback_force_a: assert property (
        running && gOp[12].op != OP_OFF && gOp[12].bad
        |=> result_q[12] == $past(gOp[12].fallback) && opBad[12])
        else $error("fallback not applied");

    bad_flag_a: assert property (
        running && gOp[12].op != OP_OFF
        |=> opBad[12] == $past(gOp[12].bad))
        else $error("bad status wrong");

    off_zero_a: assert property (
        running && gOp[0].op == OP_OFF
        |=> !result_q[0])
        else $error("off operator gave result");

    cfg_lock_a: assert property (
        !cfgMode
        |=> $stable(cfg_q[0]))
        else $error("config changed outside config mode");

    cfg_disabled_a: assert property (
        !bankEnable
        |=> $stable(cfg_q[1]))
        else $error("config changed while bank disabled");

    in1_state_a: assert property (
        running
        |=> in1State_q[1] == $past(gOp[1].b1))
        else $error("input one state wrong");

    in2_state_a: assert property (
        running
        |=> in2State_q[1] == $past(gOp[1].b2))
        else $error("input two state wrong");

    rdata_idle_a: assert property (
        !regRd
        |=> regRdata == 32'h00000000)
        else $error("read data not idle");

    ctrl_write_a: assert property (
        regWr && regAddr == REG_CTRL
        |=> ctrl_q == $past(regWdata[1:0]))
        else $error("control write lost");

    rdata_ctrl_a: assert property (
        regRd && regAddr == REG_CTRL
        |=> regRdata == {30'h00000000, $past(ctrl_q)})
        else $error("control read wrong");

    // irq lags a fresh enable by one cycle, status is already the new value
    irq_level_a: assert property (
        1'b1
        |-> irq == |(irqStatus_q & $past(irqEnable_q)))
        else $error("interrupt level wrong");

    latch_cov_c: cover property (running && gOp[4].op == OP_LATCH ##1 result_q[4]);
    fallback_cov_c: cover property (running && opBad[12]);
    irq_cov_c: cover property (irq);
    resume_cov_c: cover property (cfgMode && bankEnable ##1 running);

endmodule : logic_op_bank

/* verif/source_model.sv */
/*
 * source model: the internal parameter words and their bad flags that
 * feed the operator bank. assumes the bench calls setSrc right after a
 * rising edge of core_clk.
 */
`timescale 1ns/1ps
module source_model
    import logic_op_pkg::*;
(
    input wire logic core_clk,
    output logic [logic_op_pkg::NUM_SRC*logic_op_pkg::DATA_W-1:0] srcValues,
    output logic [logic_op_pkg::NUM_SRC-1:0] srcBad
);
    // ****************************************
    // source words
    // ****************************************
    initial begin
        srcValues = '0;
        srcBad = '0;
    end
    // signed words, changed on the edge like any other source
    task automatic setSrc(input int k, input logic [15:0] v, input logic b);
        srcValues[k*DATA_W+:DATA_W] <= v;
        srcBad[k] <= b;
    endtask : setSrc
endmodule : source_model

/* verif/tb_logic_op_bank.sv */
/*
 * testbench for the logic operator bank: register port driver, op table
 * checks, latch, fallback, suspension and interrupt scenarios.
 * assumes the source model sits on the source bus.
 */
`timescale 1ns/1ps
module tb_logic_op_bank;
    import logic_op_pkg::*;
    logic core_clk = 0;
    logic nrst = 0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [31:0] regWdata = '0;
    logic regWr = 0;
    logic regRd = 0;
    logic [31:0] regRdata, opResult, opBad;
    logic irq;
    logic [NUM_SRC*DATA_W-1:0] srcValues;
    logic [NUM_SRC-1:0] srcBad;
    int n_mismatch = 0;
    int checks = 0;
    // ****************************************
    // instances
    // ****************************************
    always #20 core_clk = ~core_clk;
    source_model source_model_inst (.core_clk(core_clk), .srcValues(srcValues),
        .srcBad(srcBad));
    logic_op_bank logic_op_bank_inst (.core_clk(core_clk), .nrst(nrst),
        .srcValues(srcValues), .srcBad(srcBad), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .opResult(opResult),
        .opBad(opBad), .irq(irq));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regWr <= 1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 0;
    endtask : wr
    // the read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regRd <= 1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 0;
        #1 d = regRdata;
    endtask : rd
    task automatic src(input int k, input logic [15:0] v, input logic b);
        @(posedge core_clk);
        source_model_inst.setSrc(k, v, b);
        repeat (3) @(posedge core_clk);
        #1;
    endtask : src
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset;
        logic [31:0] d;
        rd(REG_CTRL, d);
        chk(d, 32'h2);
        chk(opResult, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_config;
        wr(REG_CTRL, 32'h3);
        for (int i = 0; i < 10; i++) wr(REG_CFG_BASE + 8'(i), 32'h010000 | i);
        wr(REG_CFG_BASE + 8'h0a, 32'h030204);
        wr(REG_CFG_BASE + 8'h0b, 32'h050411);
        wr(REG_CFG_BASE + 8'h0c, 32'h070641);
        source_model_inst.setSrc(5, 16'h1, 0);
        source_model_inst.setSrc(7, 16'h1, 0);
        src(6, 16'h1, 1);
        wr(REG_CTRL, 32'h1);
        $display("test config done");
    endtask : t_config
    // ops 0..9 on src0/src1: off and or xor latch eq gt lt ge le
    task automatic t_table;
        src(0, 16'h5, 0);
        src(1, 16'h3, 0);
        chk(opResult & 32'h3ff, 32'h146);
        src(0, 16'h3, 0);
        chk(opResult & 32'h3ff, 32'h326);
        src(0, 16'h0, 0);
        src(1, 16'hfffe, 0);
        chk(opResult & 32'h3ff, 32'h14c);
        chk(opResult[12:11], 2'h3);
        chk(opBad[12], 1'b1);
        $display("test table done");
    endtask : t_table
    task automatic t_latch;
        logic [31:0] d;
        wr(REG_IRQ_ENABLE, 32'h400);
        wr(REG_IRQ_CLEAR, 32'hffffffff);
        src(2, 16'h1, 0);
        chk(opResult[10], 1'b1);
        chk(irq, 1'b1);
        src(2, 16'h0, 0);
        chk(opResult[10], 1'b1);
        rd(REG_IRQ_STATUS, d);
        chk(d[10], 1'b1);
        wr(REG_IRQ_CLEAR, 32'h400);
        #1 chk(irq, 1'b0);
        wr(REG_IRQ_ENABLE, 32'h0);
        src(3, 16'h1, 0);
        chk(opResult[10], 1'b0);
        src(3, 16'h0, 0);
        src(2, 16'h1, 0);
        chk(irq, 1'b0);
        rd(REG_IN1_STATE, d);
        chk(d[10], 1'b1);
        $display("test latch done");
    endtask : t_latch
    task automatic t_suspend;
        logic [31:0] d;
        wr(REG_RESULT, 32'h0);
        rd(REG_RESULT, d);
        chk(d & 32'h3ff, 32'h14c);
        rd(8'h10, d);
        chk(d, 32'h0);
        wr(REG_CFG_BASE + 8'h1, 32'h0);
        wr(REG_CTRL, 32'h3);
        src(0, 16'h5, 0);
        src(1, 16'h3, 0);
        chk(opResult & 32'h3ff, 32'h14c);
        wr(REG_CTRL, 32'h1);
        repeat (2) @(posedge core_clk);
        #1 chk(opResult & 32'h3ff, 32'h146);
        $display("test suspend done");
    endtask : t_suspend
    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (12) @(posedge core_clk);
        nrst <= 1;
        t_reset();
        t_config();
        t_table();
        t_latch();
        t_suspend();
        give_verdict();
    end
    initial begin
        #(40 * 4000);
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_logic_op_bank
